// ==== common/lpt_pkg.sv ====
package lpt_pkg;

  // Bus and value widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int TMR_W  = 16;
  localparam int BYTE_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MAXLEN    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RETRY     = 8'h08;
  localparam logic [ADDR_W-1:0] REG_DIV       = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_RTM       = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IDL       = 8'h14;
  localparam logic [ADDR_W-1:0] REG_TPL       = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_RTX_CNT   = 8'h20;
  localparam logic [ADDR_W-1:0] REG_RETRY_EXT = 8'h28;

  // Control fields
  localparam int CTRL_EXT_BIT    = 0;
  localparam int CTRL_POLL_BIT   = 1;
  localparam int CTRL_RTS_BIT    = 2;
  localparam int CTRL_TRANSP_BIT = 3;
  localparam int CTRL_RUN_BIT    = 4;
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] VAL_RST  = 16'h0000;

  // Status fields
  localparam int ST_DISC_BIT  = 0;
  localparam int ST_EXH_BIT   = 1;
  localparam int ST_T1RUN_BIT = 2;
  localparam int ST_T3RUN_BIT = 3;
  localparam int ST_SEND_BIT  = 4;
  localparam int ST_DROP_BIT  = 5;

  // Extended retry value sits in the upper byte
  localparam int RETRY_EXT_LSB = 8;

  // Divider step and terminal counts
  localparam int PRESCALE_CLKS = 32;
  localparam logic [TMR_W:0]  LEN_LAST = 17'h1_0001;
  localparam logic [BYTE_W:0] RTX_LAST = 9'h101;

  // Extended block picks the whole word, else the low byte
  function automatic logic [TMR_W-1:0] sel_val(input logic ext, input logic [TMR_W-1:0] ext_word,
                                               input logic [BYTE_W-1:0] norm_byte);
    sel_val = ext ? ext_word : {{(TMR_W-BYTE_W){1'b0}}, norm_byte};
  endfunction

endpackage

// ==== design/lpt_tick_div.sv ====
`timescale 1ns/10ps
module lpt_tick_div
  import lpt_pkg::*;
#(
  parameter int W = lpt_pkg::TMR_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Control
  input  wire logic         run,
  input  wire logic         ext,
  input  wire logic [W-1:0] period,
  // Scaled tick
  output logic              tick
);
  import lpt_pkg::*;

  localparam int PW = $clog2(PRESCALE_CLKS);
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE_CLKS - 1);

  logic [PW-1:0] presc_q, presc_d;
  logic [W:0]    cnt_q, cnt_d;
  logic [W:0]    limit;
  logic          tick_q, tick_d;
  logic          step;

  // Zero selects the longest period
  always_comb begin
    if (ext) begin
      limit = (period == '0) ? {1'b1, {W{1'b0}}} : {1'b0, period};
    end else begin
      limit = (period[BYTE_W-1:0] == '0) ? (W+1)'(1 << BYTE_W) : (W+1)'(period[BYTE_W-1:0]);
    end
  end

  assign step = run && (presc_q == PRESC_LAST);

  always_comb begin
    presc_d = run ? presc_q + 1'b1 : '0;
    cnt_d   = cnt_q;
    tick_d  = 1'b0;
    if (!run) begin
      cnt_d = '0;
    end else if (step) begin
      if (cnt_q >= limit) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc_q <= '0;
      cnt_q   <= '0;
      tick_q  <= 1'b0;
    end else begin
      presc_q <= presc_d;
      cnt_q   <= cnt_d;
      tick_q  <= tick_d;
    end
  end

  assign tick = tick_q;

  // Cycles since the last tick, for checking only
  logic [23:0] gap_q;
  logic        seen_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= tick_q ? 24'h00_0001 : gap_q + 24'h00_0001;
      seen_q <= seen_q || tick_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  tick_gap_min_a: assert property (
    (tick_q && seen_q && $past(run, 64)) |-> gap_q >= 24'h00_0040)
    else $error("tick came sooner than 64 clocks");
  tick_on_step_a: assert property (
    tick_q |-> $past(step) && $past(presc_q) == PRESC_LAST)
    else $error("tick not aligned to a 32 clock step");

endmodule

// ==== design/lpt_timer.sv ====
`timescale 1ns/10ps
module lpt_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Control
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic         tick,
  input  wire logic [W-1:0] val,
  // State
  output logic              expired,
  output logic              running
);

  logic [W-1:0] cnt_q, cnt_d;
  logic         run_q, run_d;
  logic         exp_q, exp_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    if (stop) begin
      run_d = 1'b0;
    end else if (start) begin
      cnt_d = val;
      run_d = 1'b1;
    end else if (run_q && tick) begin
      if (cnt_q == {W{1'b1}}) begin
        cnt_d = val;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
  assign running = run_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  tmr_load_a: assert property (
    (start && !stop) |=> run_q && cnt_q == $past(val))
    else $error("timer did not load its start value");
  tmr_expire_a: assert property (
    exp_q |-> $past(tick) && $past(run_q) && cnt_q == $past(val))
    else $error("timer expired without overflow or reload");

endmodule

// ==== design/lpt_top.sv ====
// Functional notes
// - Five counter/timers take start values written by the host.
// - Frame length limit is two's complement of length minus one; longer frames dropped.
// - Retry limit is two's complement of retries minus one; stop when reached.
// - Extended block option takes retry limit from upper byte of extension word.
// - Divider steps every 32 clocks; at terminal count ticks timers and reloads.
// - Retransmit, idle and poll timers count divider ticks, not clocks.
// - Divider value is its period; extended option uses full 16-bit word; the code counts value plus one 32-clock steps.
// - Divider one gives 64 clocks; zero gives 8224 or 2,097,184.
// - Missing response at retransmit timer expiry resends the control frame.
// - Link idle timer expiry marks the link disconnected.
// - With idle polling on, idle expiry starts an RR poll sequence instead.
// - Link idle timer is off while RTS control or transparent mode is set.
// - Transmit poll timer sets the interval between transmit ring checks.
// - No queued frame goes out before poll expiry, demand, or protocol reception.
// - At poll expiry every available frame in the ring is sent.
`timescale 1ns/10ps
module lpt_top (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // Register port
  input  wire logic [lpt_pkg::ADDR_W-1:0]  addr,
  input  wire logic [lpt_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [lpt_pkg::DATA_W-1:0]  rdata,
  // Frame engine events
  input  wire logic                        rx_frame_start,
  input  wire logic                        rx_byte,
  input  wire logic                        rx_frame_valid,
  input  wire logic                        ctrl_frame_sent,
  input  wire logic                        response_rcvd,
  input  wire logic                        tx_demand,
  input  wire logic                        tx_frames_avail,
  // Frame engine requests
  output logic                             frame_discard,
  output logic                             retransmit_req,
  output logic                             retry_exhausted,
  output logic                             link_disconnected,
  output logic                             idle_poll_req,
  output logic                             tx_send_en
);
  import lpt_pkg::*;

  // Host-written values
  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  logic [DATA_W-1:0] maxlen_q, maxlen_d;
  logic [DATA_W-1:0] retry_q, retry_d;
  logic [DATA_W-1:0] div_q, div_d;
  logic [DATA_W-1:0] rtm_q, rtm_d;
  logic [DATA_W-1:0] idl_q, idl_d;
  logic [DATA_W-1:0] tpl_q, tpl_d;
  logic [DATA_W-1:0] retry_ext_q, retry_ext_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  logic ext_init_block_en;
  logic idle_poll_en;
  logic rts_ctrl_en;
  logic transparent;
  logic run;

  assign ext_init_block_en = ctrl_q[CTRL_EXT_BIT];
  assign idle_poll_en      = ctrl_q[CTRL_POLL_BIT];
  assign rts_ctrl_en       = ctrl_q[CTRL_RTS_BIT];
  assign transparent       = ctrl_q[CTRL_TRANSP_BIT];
  assign run               = ctrl_q[CTRL_RUN_BIT];

  // Frame length, retry and link state
  logic [TMR_W:0]  len_cnt_q, len_cnt_d;
  logic            drop_q, drop_d;
  logic            discard_q, discard_d;
  logic [BYTE_W:0] rtx_cnt_q, rtx_cnt_d;
  logic            exh_q, exh_d;
  logic            rtx_req_q, rtx_req_d;
  logic            disc_q, disc_d;
  logic            poll_req_q, poll_req_d;
  logic            send_q, send_d;

  // Timer wiring
  logic              tick;
  logic              rtm_exp, rtm_run, rtm_start, rtm_stop;
  logic              idl_exp, idl_run, idl_start, idl_stop, idl_en;
  logic              tpl_exp, tpl_run;
  logic              rx_proto;
  logic [TMR_W-1:0]  retry_word;
  logic [BYTE_W-1:0] retry_val;
  logic              rtx_allowed;

  assign retry_word = sel_val(ext_init_block_en, {{BYTE_W{1'b0}}, retry_ext_q[RETRY_EXT_LSB +: BYTE_W]},
                              retry_q[BYTE_W-1:0]);
  assign retry_val  = retry_word[BYTE_W-1:0];

  // Register port
  always_comb begin
    ctrl_d      = ctrl_q;
    maxlen_d    = maxlen_q;
    retry_d     = retry_q;
    div_d       = div_q;
    rtm_d       = rtm_q;
    idl_d       = idl_q;
    tpl_d       = tpl_q;
    retry_ext_d = retry_ext_q;
    rdata_d     = '0;
    if (wr) begin
      case (addr)
        REG_CTRL:      ctrl_d      = wdata;
        REG_MAXLEN:    maxlen_d    = wdata;
        REG_RETRY:     retry_d     = wdata;
        REG_DIV:       div_d       = wdata;
        REG_RTM:       rtm_d       = wdata;
        REG_IDL:       idl_d       = wdata;
        REG_TPL:       tpl_d       = wdata;
        REG_RETRY_EXT: retry_ext_d = wdata;
        default:       ctrl_d      = ctrl_q;
      endcase
    end
    if (rd) begin
      case (addr)
        REG_CTRL:      rdata_d = ctrl_q;
        REG_MAXLEN:    rdata_d = maxlen_q;
        REG_RETRY:     rdata_d = retry_q;
        REG_DIV:       rdata_d = div_q;
        REG_RTM:       rdata_d = rtm_q;
        REG_IDL:       rdata_d = idl_q;
        REG_TPL:       rdata_d = tpl_q;
        REG_RETRY_EXT: rdata_d = retry_ext_q;
        REG_RTX_CNT:   rdata_d = {{(DATA_W-BYTE_W-1){1'b0}}, rtx_cnt_q};
        REG_STATUS: begin
          rdata_d[ST_DISC_BIT]  = disc_q;
          rdata_d[ST_EXH_BIT]   = exh_q;
          rdata_d[ST_T1RUN_BIT] = rtm_run;
          rdata_d[ST_T3RUN_BIT] = idl_run;
          rdata_d[ST_SEND_BIT]  = send_q;
          rdata_d[ST_DROP_BIT]  = drop_q;
        end
        default:       rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q      <= CTRL_RST;
      maxlen_q    <= VAL_RST;
      retry_q     <= VAL_RST;
      div_q       <= VAL_RST;
      rtm_q       <= VAL_RST;
      idl_q       <= VAL_RST;
      tpl_q       <= VAL_RST;
      retry_ext_q <= VAL_RST;
      rdata_q     <= '0;
    end else begin
      ctrl_q      <= ctrl_d;
      maxlen_q    <= maxlen_d;
      retry_q     <= retry_d;
      div_q       <= div_d;
      rtm_q       <= rtm_d;
      idl_q       <= idl_d;
      tpl_q       <= tpl_d;
      retry_ext_q <= retry_ext_d;
      rdata_q     <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // Shared scaled tick
  lpt_tick_div #(.W(TMR_W)) u_div (
    .clk    (clk),
    .rstn   (rstn),
    .run    (run),
    .ext    (ext_init_block_en),
    .period (div_q),
    .tick   (tick)
  );

  // Retransmit timer runs until the response arrives or retries run out
  assign rtm_start = run && ctrl_frame_sent;
  assign rtm_stop  = !run || response_rcvd || (rtm_exp && !rtx_allowed);

  lpt_timer #(.W(TMR_W)) u_rtm (
    .clk     (clk),
    .rstn    (rstn),
    .start   (rtm_start),
    .stop    (rtm_stop),
    .tick    (tick),
    .val     (rtm_q),
    .expired (rtm_exp),
    .running (rtm_run)
  );

  // Idle timer restarts on each good frame
  assign idl_en    = run && !rts_ctrl_en && !transparent;
  assign idl_start = idl_en && (!idl_run || rx_frame_valid);
  assign idl_stop  = !idl_en;

  lpt_timer #(.W(TMR_W)) u_idl (
    .clk     (clk),
    .rstn    (rstn),
    .start   (idl_start),
    .stop    (idl_stop),
    .tick    (tick),
    .val     (idl_q),
    .expired (idl_exp),
    .running (idl_run)
  );

  // Transmit poll timer free-runs while enabled
  lpt_timer #(.W(TMR_W)) u_tpl (
    .clk     (clk),
    .rstn    (rstn),
    .start   (run && !tpl_run),
    .stop    (!run),
    .tick    (tick),
    .val     (tpl_q),
    .expired (tpl_exp),
    .running (tpl_run)
  );

  assign rx_proto    = rx_frame_valid && !transparent;
  assign rtx_allowed = (rtx_cnt_q != RTX_LAST);

  // Frame length, retry, idle and transmit gating
  always_comb begin
    len_cnt_d  = len_cnt_q;
    drop_d     = drop_q;
    discard_d  = 1'b0;
    rtx_cnt_d  = rtx_cnt_q;
    exh_d      = exh_q;
    rtx_req_d  = 1'b0;
    disc_d     = disc_q;
    poll_req_d = 1'b0;
    send_d     = send_q;
    if (rx_frame_start) begin
      len_cnt_d = {1'b0, maxlen_q};
      drop_d    = 1'b0;
    end else if (rx_byte && !drop_q) begin
      if (len_cnt_q == LEN_LAST) begin
        drop_d    = 1'b1;
        discard_d = 1'b1;
      end else begin
        len_cnt_d = len_cnt_q + 1'b1;
      end
    end
    if (rtm_start) begin
      rtx_cnt_d = {1'b0, retry_val};
      exh_d     = 1'b0;
    end else if (rtm_exp && rtm_run) begin
      if (rtx_allowed) begin
        rtx_req_d = 1'b1;
        rtx_cnt_d = rtx_cnt_q + 1'b1;
      end else begin
        exh_d = 1'b1;
      end
    end
    // A good frame clears the disconnect, but a same-cycle expiry with polling off wins
    if (rx_frame_valid || !run) begin
      disc_d = 1'b0;
    end
    if (idl_exp && idl_run) begin
      if (idle_poll_en) begin
        poll_req_d = 1'b1;
      end else begin
        disc_d = 1'b1;
      end
    end
    // Drain holds until the ring is empty so every ready frame goes
    if (!tx_frames_avail || !run) begin
      send_d = 1'b0;
    end else if (tpl_exp || tx_demand || rx_proto) begin
      send_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      len_cnt_q  <= '0;
      drop_q     <= 1'b0;
      discard_q  <= 1'b0;
      rtx_cnt_q  <= '0;
      exh_q      <= 1'b0;
      rtx_req_q  <= 1'b0;
      disc_q     <= 1'b0;
      poll_req_q <= 1'b0;
      send_q     <= 1'b0;
    end else begin
      len_cnt_q  <= len_cnt_d;
      drop_q     <= drop_d;
      discard_q  <= discard_d;
      rtx_cnt_q  <= rtx_cnt_d;
      exh_q      <= exh_d;
      rtx_req_q  <= rtx_req_d;
      disc_q     <= disc_d;
      poll_req_q <= poll_req_d;
      send_q     <= send_d;
    end
  end

  assign frame_discard     = discard_q;
  assign retransmit_req    = rtx_req_q;
  assign retry_exhausted   = exh_q;
  assign link_disconnected = disc_q;
  assign idle_poll_req     = poll_req_q;
  assign tx_send_en        = send_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence last_retry_s;
    rtm_exp && rtm_run && !rtm_start && rtx_cnt_q == RTX_LAST;
  endsequence
  sequence exhausted_s;
    exh_q && !rtx_req_q ##1 !rtm_run;
  endsequence

  retry_stop_a: assert property (
    last_retry_s |=> exhausted_s)
    else $error("retries not stopped at the limit");
  resend_a: assert property (
    (rtm_exp && rtm_run && !rtm_start && rtx_allowed) |=> retransmit_req && rtx_cnt_q == $past(rtx_cnt_q) + 9'h001)
    else $error("expiry did not resend the control frame");
  disc_set_a: assert property (
    (idl_exp && idl_run && !idle_poll_en) |=> link_disconnected && !idle_poll_req)
    else $error("idle expiry did not mark disconnect");
  idle_poll_a: assert property (
    (idl_exp && idl_run && idle_poll_en) |=>
      idle_poll_req && link_disconnected == $past(link_disconnected && !rx_frame_valid && run))
    else $error("idle expiry did not start polling");
  idle_off_a: assert property (
    (rts_ctrl_en || transparent) |=> !idl_run ##1 !idle_poll_req && !$rose(link_disconnected))
    else $error("idle timer ran while disabled");
  tx_hold_a: assert property (
    $rose(tx_send_en) |-> $past(tpl_exp || tx_demand || rx_proto))
    else $error("transmit started without a trigger");
  tx_drain_a: assert property (
    (tx_send_en && tx_frames_avail && run) |=> tx_send_en)
    else $error("transmit drain ended with frames left");
  len_drop_a: assert property (
    (rx_byte && !rx_frame_start && !drop_q && len_cnt_q == LEN_LAST) |=> frame_discard ##1 !frame_discard)
    else $error("overlong frame not discarded");

endmodule

// ==== tb/lpt_frame_model.sv ====
`timescale 1ns/10ps
module lpt_frame_model #(
  parameter int GAP = 2
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Bench commands
  input  wire logic       go,
  input  wire logic [7:0] len,
  input  wire logic       ring_set,
  input  wire logic [7:0] ring_load,
  // Device side
  input  wire logic       tx_send_en,
  output logic            rx_frame_start,
  output logic            rx_byte,
  output logic            tx_frames_avail,
  output logic [7:0]      sent
);
  logic [7:0] left_q;
  logic [7:0] ring_q;
  logic [3:0] gap_q;
  logic [3:0] tgap_q;
  assign tx_frames_avail = (ring_q != 8'h00);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {left_q, ring_q, gap_q, tgap_q, sent} <= '0;
      rx_frame_start <= 1'b0;
      rx_byte <= 1'b0;
    end else begin
      // Bytes spaced out: a slow line, not one byte a clock
      rx_frame_start <= go;
      rx_byte <= 1'b0;
      if (go) begin
        left_q <= len;
        gap_q <= 4'(GAP);
      end else if (left_q != 8'h00) begin
        if (gap_q == 4'h0) begin
          rx_byte <= 1'b1;
          left_q <= left_q - 8'h01;
          gap_q <= 4'(GAP);
        end else begin
          gap_q <= gap_q - 4'h1;
        end
      end
      // Ring drains one frame at a time only while sending is allowed
      if (ring_set) begin
        ring_q <= ring_load;
      end else if (tx_send_en && tx_frames_avail) begin
        if (tgap_q == 4'h0) begin
          ring_q <= ring_q - 8'h01;
          sent <= sent + 8'h01;
          tgap_q <= 4'(GAP * 4);
        end else begin
          tgap_q <= tgap_q - 4'h1;
        end
      end
    end
  end
endmodule

// ==== tb/lpt_top_bench.sv ====
`timescale 1ns/10ps
module lpt_top_bench;
  import lpt_pkg::*;
  typedef struct {
    logic [15:0] ctrl;
    logic [15:0] div;
    logic [15:0] idl;
    logic [15:0] per;
  } lpt_tick_row_s;
  typedef struct {
    logic [7:0]  a;
    logic [15:0] d;
    logic [15:0] q;
  } lpt_reg_row_s;
  localparam int LIMIT = 90000;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [3:0]  ev = 4'h0;
  logic        go = 1'b0;
  logic [7:0]  len = 8'h00;
  logic        ring_set = 1'b0;
  logic [7:0]  ring_load = 8'h00;
  logic        rx_frame_start, rx_byte, tx_frames_avail;
  logic        frame_discard, retransmit_req, retry_exhausted;
  logic        link_disconnected, idle_poll_req, tx_send_en;
  logic [7:0]  sent;
  logic [5:0]  outs;
  int          errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;
  // Idle polling reloads each expiry, so pulse spacing is one tick period, two with idle value fffe
  lpt_tick_row_s ticks[6] = '{
    '{16'h0012, 16'h0001, 16'hffff, 16'h0040},
    '{16'h0012, 16'h0001, 16'hfffe, 16'h0080},
    '{16'h0012, 16'h0003, 16'hffff, 16'h0080},
    '{16'h0012, 16'h0201, 16'hffff, 16'h0040},
    '{16'h0013, 16'h0201, 16'hffff, 16'h4040},
    '{16'h0012, 16'h0000, 16'hffff, 16'h2020}};
  lpt_reg_row_s regs[10] = '{
    '{REG_MAXLEN, 16'hfffd, 16'hfffd}, '{REG_RTM, 16'h1234, 16'h1234},
    '{REG_IDL, 16'habcd, 16'habcd}, '{REG_TPL, 16'h5a5a, 16'h5a5a},
    '{REG_RETRY, 16'h00fe, 16'h00fe}, '{REG_DIV, 16'h0003, 16'h0003},
    '{REG_RETRY_EXT, 16'hff00, 16'hff00}, '{REG_STATUS, 16'hffff, 16'h0000},
    '{8'h24, 16'hffff, 16'h0000}, '{8'h30, 16'hffff, 16'h0000}};

  assign outs = {frame_discard, retransmit_req, retry_exhausted, link_disconnected, idle_poll_req, tx_send_en};
  always #20 clk = ~clk;

  lpt_top dut_u (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rx_frame_start(rx_frame_start), .rx_byte(rx_byte), .rx_frame_valid(ev[0]),
    .ctrl_frame_sent(ev[1]), .response_rcvd(ev[2]), .tx_demand(ev[3]),
    .tx_frames_avail(tx_frames_avail), .frame_discard(frame_discard),
    .retransmit_req(retransmit_req), .retry_exhausted(retry_exhausted),
    .link_disconnected(link_disconnected), .idle_poll_req(idle_poll_req), .tx_send_en(tx_send_en));

  lpt_frame_model fm_u (
    .clk(clk), .rstn(rstn), .go(go), .len(len), .ring_set(ring_set), .ring_load(ring_load),
    .tx_send_en(tx_send_en), .rx_frame_start(rx_frame_start), .rx_byte(rx_byte),
    .tx_frames_avail(tx_frames_avail), .sent(sent));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Extra idle cycle so a strobe is never dropped and raised in one step
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    check(rdata, exp);
  endtask

  task automatic fire(input logic [3:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
  endtask

  task automatic load_ring(input logic [7:0] k);
    ring_load <= k;
    ring_set <= 1'b1;
    @(posedge clk);
    ring_set <= 1'b0;
    @(posedge clk);
  endtask

  task automatic finish_test;
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check({10'h000, outs}, 16'h0000);
    check(rdata, 16'h0000);
    foreach (regs[i]) begin
      wr_reg(regs[i].a, regs[i].d);
      rd_reg(regs[i].a, regs[i].q);
    end
    // Retries: low byte gives three, extension word gives two
    wr_reg(REG_DIV, 16'h0001);
    wr_reg(REG_RTM, 16'hffff);
    for (int e = 0; e < 2; e++) begin
      wr_reg(REG_CTRL, 16'h0000);
      wr_reg(REG_CTRL, e ? 16'h0011 : 16'h0010);
      fire(4'h2);
      n = 0;
      repeat (800) begin
        @(posedge clk);
        if (retransmit_req === 1'b1) n++;
      end
      check(16'(n), e ? 16'h0002 : 16'h0003);
      check({15'h0000, retry_exhausted}, 16'h0001);
      rd_reg(REG_RTX_CNT, 16'h0101);
      rd_reg(REG_STATUS, 16'h000a);
    end
    // Answer arrives before expiry; two ticks leave room for it
    wr_reg(REG_RTM, 16'hfffe);
    fire(4'h2);
    check({15'h0000, retry_exhausted}, 16'h0000);
    fire(4'h4);
    n = 0;
    repeat (400) begin
      @(posedge clk);
      if (retransmit_req === 1'b1) n++;
    end
    check(16'(n), 16'h0000);
    // Idle expiry without polling
    wr_reg(REG_IDL, 16'hfffe);
    wr_reg(REG_CTRL, 16'h0000);
    wr_reg(REG_CTRL, 16'h0010);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (idle_poll_req === 1'b1) n++;
    end
    check({15'h0000, link_disconnected}, 16'h0001);
    check(16'(n), 16'h0000);
    fire(4'h1);
    check({15'h0000, link_disconnected}, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      wr_reg(REG_CTRL, 16'h0000);
      wr_reg(REG_CTRL, k ? 16'h0018 : 16'h0014);
      repeat (400) @(posedge clk);
      check({15'h0000, link_disconnected}, 16'h0000);
    end
    // Length limit of four bytes
    wr_reg(REG_MAXLEN, 16'hfffd);
    for (int k = 4; k < 7; k += 2) begin
      len <= 8'(k);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      repeat (40) begin
        @(posedge clk);
        if (frame_discard === 1'b1) n++;
      end
      check(16'(n), (k == 4) ? 16'h0000 : 16'h0001);
    end
    // Poll period of 16 ticks, frames queued before run
    wr_reg(REG_CTRL, 16'h0000);
    wr_reg(REG_TPL, 16'hfff0);
    load_ring(8'h03);
    wr_reg(REG_CTRL, 16'h0010);
    repeat (950) @(posedge clk);
    check({15'h0000, tx_send_en}, 16'h0000);
    n = 0;
    while (tx_send_en !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check({15'h0000, tx_send_en}, 16'h0001);
    n = 0;
    while (tx_frames_avail !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check({8'h00, sent}, 16'h0003);
    repeat (3) @(posedge clk);
    check({15'h0000, tx_send_en}, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      load_ring(8'h03);
      fire(k ? 4'h8 : 4'h1);
      repeat (3) @(posedge clk);
      check({15'h0000, tx_send_en}, 16'h0001);
      repeat (60) @(posedge clk);
    end
    check({8'h00, sent}, 16'h0009);
    foreach (ticks[i]) begin
      wr_reg(REG_CTRL, 16'h0000);
      wr_reg(REG_DIV, ticks[i].div);
      wr_reg(REG_IDL, ticks[i].idl);
      wr_reg(REG_CTRL, ticks[i].ctrl);
      n = 0;
      while (idle_poll_req !== 1'b1 && n < 20000) begin
        @(posedge clk);
        n++;
      end
      @(posedge clk);
      n = 1;
      while (idle_poll_req !== 1'b1 && n < 20000) begin
        @(posedge clk);
        n++;
      end
      check(16'(n), ticks[i].per);
      check({15'h0000, link_disconnected}, 16'h0000);
    end
    // Reset while timers run
    rstn <= 1'b0;
    @(posedge clk);
    check({10'h000, outs}, 16'h0000);
    finish_test();
  end
endmodule
